// ===== core/datetime_store.sv
module datetime_store
   import panel_flags_pkg::*;
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // write side
   input  wire logic       time_we,
   input  wire time_type   time_in,
   input  wire logic       date_we,
   input  wire date_type   date_in,
   // read side
   input  wire logic [2:0] rd_addr,
   output logic      [7:0] rd_data
);

   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] mem_d [MEM_DEPTH];
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;

   // whole groups are written at once so a reader never sees half an update
   always_comb
   begin
      mem_d = mem_q;
      if (time_we)
      begin
         mem_d[MEM_TIME]        = time_in.hours;
         mem_d[MEM_TIME + 3'h1] = time_in.minutes;
         mem_d[MEM_TIME + 3'h2] = time_in.seconds;
      end
      if (date_we)
      begin
         mem_d[MEM_DATE]        = date_in.weekday;
         mem_d[MEM_DATE + 3'h1] = date_in.day;
         mem_d[MEM_DATE + 3'h2] = date_in.month;
         mem_d[MEM_DATE + 3'h3] = date_in.year;
      end
      rd_data_d = (rd_addr < 3'h7) ? mem_q[rd_addr] : 8'h00;
   end

   // storage and registered read port
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mem_q     <= '{default: 8'h00};
         rd_data_q <= 8'h00;
      end
      else
      begin
         mem_q     <= mem_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_data = rd_data_q;

endmodule // datetime_store

// ===== core/heartbeat_timer.sv
module heartbeat_timer
   import panel_flags_pkg::*;
#(
   parameter int unsigned CYCLES = HB_CYCLES
)
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // one-cycle enable each period
   output logic      tick
);

   logic [31:0] count_q;
   logic [31:0] count_d;
   logic        tick_q;
   logic        tick_d;

   // period rounds down so the flip never comes late
   always_comb
   begin
      tick_d  = (count_q == CYCLES - 32'h1);
      count_d = tick_d ? 32'h0 : count_q + 32'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // first period starts one step in: the flip lands a cycle after the tick
         count_q <= 32'h1;
         tick_q  <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         tick_q  <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule // heartbeat_timer

// ===== core/panel_flags_pkg.sv
package panel_flags_pkg;

   // bus shape
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;

   // timing: the ready heartbeat must flip at least once per second
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned HB_PERIOD_NS  = 1_000_000_000;
   localparam int unsigned HB_CYCLES     = HB_PERIOD_NS / CLK_PERIOD_NS;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_EVENT   = 6'h00;
   localparam logic [5:0] IDX_PANEL   = 6'h01;
   localparam logic [5:0] IDX_MAILBOX = 6'h03;
   localparam logic [5:0] IDX_JOB     = 6'h04;
   localparam logic [5:0] IDX_TIME    = 6'h0f;
   localparam logic [5:0] IDX_DATE    = 6'h15;
   localparam logic [5:0] TIME_BYTES  = 6'h03;
   localparam logic [5:0] DATE_BYTES  = 6'h04;

   // field positions
   localparam int unsigned EV_DATE     = 5;
   localparam int unsigned EV_TIME     = 6;
   localparam int unsigned EV_CYCLIC   = 7;
   localparam int unsigned PS_STARTUP  = 0;
   localparam int unsigned PS_OFFLINE  = 1;
   localparam int unsigned PS_READY    = 2;
   localparam int unsigned MB_DISABLED = 0;
   localparam int unsigned MB_FAULTY   = 1;
   localparam int unsigned MB_CORRECT  = 2;
   localparam int unsigned MB_DONE     = 3;
   localparam int unsigned MB_REQUEST  = 4;
   localparam int unsigned MB_DO_READ  = 5;
   localparam int unsigned MB_DIS_REQ  = 6;
   localparam int unsigned MB_HAS_READ = 7;

   // reset values and masks
   localparam logic [7:0]  EVENT_RST    = 8'h00;
   localparam logic [7:0]  PANEL_RST    = 8'h00;
   localparam logic [7:0]  MAILBOX_RST  = 8'h00;
   localparam logic [15:0] JOB_RST      = 16'h0000;
   localparam logic [7:0]  EVENT_W1C    = 8'he0;
   localparam logic [7:0]  PANEL_W1C    = 8'h01;
   localparam logic [7:0]  MB_CTRL_SET  = 8'h7e;

   // bus responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // date and time byte store
   localparam int unsigned MEM_DEPTH    = 7;
   localparam logic [2:0]  MEM_TIME     = 3'h0;
   localparam logic [2:0]  MEM_DATE     = 3'h3;

   typedef struct packed {
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } time_type;

   typedef struct packed {
      logic [7:0] weekday;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] year;
   } date_type;

   typedef struct packed {
      logic [7:0] set;
      logic [7:0] clr;
   } mbox_cmd_type;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00, RD_ADDR = 2'b01, RD_DATA = 2'b11, RD_RESP = 2'b10
   } rd_state_type;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b00, WR_APPLY = 2'b01, WR_RESP = 2'b11
   } wr_state_type;

   // true when both nibbles are decimal digits
   function automatic logic bcd_ok(input logic [7:0] b);
      return (b[7:4] < 4'ha) && (b[3:0] < 4'ha);
   endfunction

endpackage

// ===== core/panel_handshake_flags.sv
// Chosen here: the AXI4-Lite interface to the registers.
module panel_handshake_flags
   import panel_flags_pkg::*;
#(
   parameter int unsigned HEARTBEAT_CYCLES = HB_CYCLES
)
(
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write channels
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // axi4-lite read channels
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [DATA_W-1:0]        rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // panel events
   input  wire logic                time_new,
   input  wire time_type            time_in,
   input  wire logic                date_new,
   input  wire date_type            date_in,
   input  wire logic                cyclic_event,
   input  wire logic                offline_mode,
   // panel mailbox and job handling
   input  wire mbox_cmd_type        mbox_cmd,
   input  wire logic                mbox_read,
   input  wire logic                job_done,
   output logic [15:0]              job_number,
   output logic                     job_pending,
   output logic [7:0]               mailbox_flags
);

   // decode a byte address to a mapped register
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [5:0] i;
      i = a[7:2];
      return (a[1:0] == 2'h0) &&
             (i == IDX_EVENT || i == IDX_PANEL || i == IDX_MAILBOX || i == IDX_JOB ||
              (i >= IDX_TIME && i < IDX_TIME + TIME_BYTES) ||
              (i >= IDX_DATE && i < IDX_DATE + DATE_BYTES));
   endfunction

   rd_state_type      rd_q, rd_d;
   wr_state_type      wr_q, wr_d;
   logic [ADDR_W-1:0] araddr_q, araddr_d, awaddr_q, awaddr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]        wstrb_q, wstrb_d;
   logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic              awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0]        event_q, event_d, panel_q, panel_d, mailbox_q, mailbox_d;
   logic [15:0]       job_q, job_d;
   logic              job_pending_q, job_pending_d;
   logic              boot_q, boot_d;
   logic              hb_tick;
   logic [7:0]        mem_rdata;
   logic [2:0]        mem_addr;
   logic [5:0]        rd_idx, wr_idx;
   logic              apply;
   logic [7:0]        lane0, lane1;
   logic              time_ok, date_ok;

   // only well-formed bcd deliveries are stored and flagged
   assign time_ok = time_new && bcd_ok(time_in.hours) && bcd_ok(time_in.minutes) &&
                    bcd_ok(time_in.seconds);
   assign date_ok = date_new && bcd_ok(date_in.weekday) && bcd_ok(date_in.day) &&
                    bcd_ok(date_in.month) && bcd_ok(date_in.year);

   // store index for the held read address
   assign rd_idx   = araddr_q[7:2];
   assign mem_addr = (rd_idx >= IDX_DATE) ? MEM_DATE + 3'(rd_idx - IDX_DATE)
                                          : MEM_TIME + 3'(rd_idx - IDX_TIME);

   datetime_store u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .time_we (time_ok),
      .time_in (time_in),
      .date_we (date_ok),
      .date_in (date_in),
      .rd_addr (mem_addr),
      .rd_data (mem_rdata)
   );

   heartbeat_timer #(.CYCLES(HEARTBEAT_CYCLES)) u_beat (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (hb_tick)
   );

   // write channel: address and data taken in either order, applied once both held
   always_comb
   begin
      wr_d      = wr_q;
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      case (wr_q)
         WR_COLLECT:
         begin
            if (awvalid && awready_q)
            begin
               aw_held_d = 1'b1;
               awaddr_d  = awaddr;
            end
            if (wvalid && wready_q)
            begin
               w_held_d = 1'b1;
               wdata_d  = wdata;
               wstrb_d  = wstrb;
            end
            if (aw_held_d && w_held_d)
               wr_d = WR_APPLY;
         end
         WR_APPLY:
         begin
            bvalid_d = 1'b1;
            bresp_d  = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            wr_d     = WR_RESP;
         end
         WR_RESP:
         begin
            if (bready)
            begin
               bvalid_d  = 1'b0;
               aw_held_d = 1'b0;
               w_held_d  = 1'b0;
               wr_d      = WR_COLLECT;
            end
         end
         default:
            wr_d = WR_COLLECT;
      endcase
      awready_d = (wr_d == WR_COLLECT) && !aw_held_d;
      wready_d  = (wr_d == WR_COLLECT) && !w_held_d;
   end

   // read channel: one spare cycle lets the byte store register its output
   always_comb
   begin
      rd_d      = rd_q;
      araddr_d  = araddr_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      rvalid_d  = rvalid_q;
      case (rd_q)
         RD_IDLE:
         begin
            if (arvalid && arready_q)
            begin
               araddr_d = araddr;
               rd_d     = RD_ADDR;
            end
         end
         RD_ADDR:
            rd_d = RD_DATA;
         RD_DATA:
         begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = 32'h0;
            if (!mapped(araddr_q))
               rdata_d = 32'h0;
            else if (rd_idx == IDX_EVENT)
               rdata_d[7:0] = event_q;
            else if (rd_idx == IDX_PANEL)
               rdata_d[7:0] = panel_q;
            else if (rd_idx == IDX_MAILBOX)
               rdata_d[7:0] = mailbox_q;
            else if (rd_idx == IDX_JOB)
               rdata_d[15:0] = job_q;
            else
               rdata_d[7:0] = mem_rdata;
            rd_d = RD_RESP;
         end
         RD_RESP:
         begin
            if (rready)
            begin
               rvalid_d = 1'b0;
               rd_d     = RD_IDLE;
            end
         end
         default:
            rd_d = RD_IDLE;
      endcase
      arready_d = (rd_d == RD_IDLE);
   end

   // write strobes gate byte lanes 0 and 1; lanes 2 and 3 are not used
   assign wr_idx = awaddr_q[7:2];
   assign apply  = (wr_q == WR_APPLY) && mapped(awaddr_q);
   assign lane0  = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
   assign lane1  = wstrb_q[1] ? wdata_q[15:8] : 8'h00;

   // flag bytes: clears come first, so a same-cycle event always survives
   always_comb
   begin
      event_d   = event_q;
      panel_d   = panel_q;
      mailbox_d = mailbox_q;
      job_d     = job_q;
      boot_d    = 1'b0;
      if (apply && wr_idx == IDX_EVENT)
         event_d = event_q & ~(lane0 & EVENT_W1C);
      if (apply && wr_idx == IDX_PANEL)
         panel_d = panel_q & ~(lane0 & PANEL_W1C);
      if (apply && wr_idx == IDX_MAILBOX)
      begin
         // controller may clear the disable bit but never set it
         mailbox_d = (mailbox_q & ~lane1) | (lane0 & MB_CTRL_SET);
      end
      mailbox_d = (mailbox_d & ~mbox_cmd.clr) | mbox_cmd.set;
      if (mbox_read)
         mailbox_d[MB_HAS_READ] = 1'b1;
      if (time_ok)
         event_d[EV_TIME] = 1'b1;
      if (date_ok)
         event_d[EV_DATE] = 1'b1;
      if (cyclic_event)
         event_d[EV_CYCLIC] = 1'b1;
      if (boot_q)
         panel_d[PS_STARTUP] = 1'b1;
      panel_d[PS_OFFLINE] = offline_mode;
      if (hb_tick)
         panel_d[PS_READY] = ~panel_q[PS_READY];
      // a fresh job number written in the same cycle outlives the zeroing
      if (job_done)
         job_d = JOB_RST;
      if (apply && wr_idx == IDX_JOB)
      begin
         if (wstrb_q[0])
            job_d[7:0] = wdata_q[7:0];
         if (wstrb_q[1])
            job_d[15:8] = wdata_q[15:8];
      end
      job_pending_d = (job_d != JOB_RST);
   end

   // all state registers except the heartbeat age used by the checks
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_q <= WR_COLLECT;
         rd_q <= RD_IDLE;
         {aw_held_q, w_held_q, bvalid_q, rvalid_q} <= 4'h0;
         {awready_q, wready_q, arready_q} <= 3'h0;
         awaddr_q <= 8'h00;
         araddr_q <= 8'h00;
         wdata_q <= 32'h0;
         rdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bresp_q <= RESP_OKAY;
         rresp_q <= RESP_OKAY;
         event_q <= EVENT_RST;
         panel_q <= PANEL_RST;
         mailbox_q <= MAILBOX_RST;
         job_q <= JOB_RST;
         job_pending_q <= 1'b0;
         boot_q <= 1'b1;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         {aw_held_q, w_held_q, bvalid_q, rvalid_q} <= {aw_held_d, w_held_d, bvalid_d, rvalid_d};
         {awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
         awaddr_q <= awaddr_d;
         araddr_q <= araddr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         event_q <= event_d;
         panel_q <= panel_d;
         mailbox_q <= mailbox_d;
         job_q <= job_d;
         job_pending_q <= job_pending_d;
         boot_q <= boot_d;
      end
   end

   // outputs straight from flops
   assign awready       = awready_q;
   assign wready        = wready_q;
   assign bvalid        = bvalid_q;
   assign bresp         = bresp_q;
   assign arready       = arready_q;
   assign rvalid        = rvalid_q;
   assign rdata         = rdata_q;
   assign rresp         = rresp_q;
   assign job_number    = job_q;
   assign job_pending   = job_pending_q;
   assign mailbox_flags = mailbox_q;

   // age of the ready bit, read only by the checks below
   logic [31:0] hb_age_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || panel_d[PS_READY] != panel_q[PS_READY])
         hb_age_q <= 32'h0;
      else
         hb_age_q <= hb_age_q + 32'h1;
   end

   a_time_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      time_ok |=> event_q[EV_TIME]) else $error("time flag not set");
   a_date_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      date_ok |=> event_q[EV_DATE])
      else $error("date flag not set");
   a_cyclic_wins_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      cyclic_event |=> event_q[EV_CYCLIC] ##1 (event_q[EV_CYCLIC] || $past(apply)))
      else $error("cyclic summary lost");
   a_startup_after_boot: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(boot_q) |-> panel_q[PS_STARTUP]) else $error("startup bit not set");
   a_offline_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 panel_q[PS_OFFLINE] == $past(offline_mode)) else $error("offline bit stale");
   a_ready_bit_alive: assert property (@(posedge aclk) disable iff (!aresetn)
      hb_age_q < HEARTBEAT_CYCLES) else $error("ready bit stuck");
   a_disable_owner: assert property (@(posedge aclk) disable iff (!aresetn)
      (!mailbox_q[MB_DISABLED] && !mbox_cmd.set[MB_DISABLED]) |=> !mailbox_q[MB_DISABLED])
      else $error("mailbox disabled by controller");
   a_mailbox_read: assert property (@(posedge aclk) disable iff (!aresetn)
      mbox_read |=> mailbox_q[MB_HAS_READ]) else $error("read flag missing");
   a_job_zeroed: assert property (@(posedge aclk) disable iff (!aresetn)
      job_done && !(apply && wr_idx == IDX_JOB) |=> job_q == JOB_RST && !job_pending_q)
      else $error("job word not zeroed");

endmodule // panel_handshake_flags

// ===== testbench/controller_model.sv
// control program side: a bus master that owns the register bus
module controller_model
(
   // clock
   input  wire logic        aclk,
   // write channels
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic             bready,
   // read channels
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic        rvalid,
   output logic             rready
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // each handshake is judged at the rising edge, with the values standing just before it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1)
         begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask

   // one read; the answer is also handed back for the bench's own use
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask
endmodule // controller_model

// ===== testbench/tb_panel_handshake_flags.sv
module tb_panel_handshake_flags;
   import panel_flags_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned HB = 16;

   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, time_new, date_new, cyclic_event;
   logic offline_mode, mbox_read, job_done, job_pending;
   logic [7:0]  awaddr, araddr, mailbox_flags;
   logic [31:0] wdata, rdata, d, r, cyc, t0;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] job_number;
   time_type     time_in, tv;
   date_type     date_in, dv;
   mbox_cmd_type mbox_cmd;
   logic [65:0]  rq[$];
   logic [1:0]   bq[$];
   int           miscompares, num_checks, flips;

   panel_handshake_flags #(.HEARTBEAT_CYCLES(HB)) panel_handshake_flags_inst (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .time_new, .time_in,
      .date_new, .date_in, .cyclic_event, .offline_mode, .mbox_cmd, .mbox_read, .job_done,
      .job_number, .job_pending, .mailbox_flags);
   controller_model controller_model_inst (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready);

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 32'h1;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // each answer taken off the bus meets the oldest note
   always @(negedge aclk)
   begin
      if (rvalid === 1'b1 && rready)
      begin
         check("rdata", rdata & rq[0][63:32], rq[0][31:0]);
         check("rresp", {30'h0, rresp}, {30'h0, rq[0][65:64]});
         void'(rq.pop_front());
      end
      if (bvalid === 1'b1 && bready)
         check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
   end

   // note the expected answer, then let the controller move the word
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] rs);
      rq.push_back({rs, m, e & m});
      controller_model_inst.rd(a, d);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] rs);
      bq.push_back(rs);
      controller_model_inst.wr(a, v, s);
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [7:0] to_bcd(input logic [31:0] v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction

   // a one-cycle panel pulse
   task automatic pulse_edge();
      @(posedge aclk);
      {time_new, date_new, cyclic_event, mbox_read, job_done} <= '0;
      mbox_cmd <= '0;
   endtask

   // a hang ends the run through the same closing path
   initial
   begin
      repeat (4000) @(posedge aclk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      {aclk, aresetn, time_new, date_new, cyclic_event, offline_mode, mbox_read} = '0;
      {job_done, cyc, time_in, date_in, mbox_cmd, flips} = '0;
      r = 32'h77f48568;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(8'h04, 32'h1, 32'h3, RESP_OKAY);
      offline_mode <= 1'b1;
      rd(8'h04, 32'h3, 32'h3, RESP_OKAY);
      offline_mode <= 1'b0;
      wr(8'h04, 32'h1, 4'hf, RESP_OKAY);
      rd(8'h04, 32'h0, 32'h3, RESP_OKAY);
      // every flip is seen since reads come faster than the flip period
      t0 = cyc;
      for (int i = 0; i < 12; i++)
      begin
         rd(8'h04, 32'h0, 32'h0, RESP_OKAY);
         if (i > 0 && d[2] !== r[2]) flips++;
         r[2] = d[2];
      end
      check("heartbeat", 32'(flips + 1 >= (cyc - t0) / HB), 32'h1);
      // random deliveries in decimal digits; the generator restarts from its seed
      r = 32'h77f48568;
      for (int k = 0; k < 3; k++)
      begin
         r = lfsr(r);
         tv = {to_bcd(r % 24), to_bcd((r >> 8) % 60), to_bcd((r >> 16) % 60)};
         dv = {to_bcd(r % 7 + 1), to_bcd(r % 31 + 1), to_bcd(r % 12 + 1), to_bcd(r % 100)};
         time_in <= tv;
         date_in <= dv;
         {time_new, date_new, cyclic_event} <= 3'b111;
         pulse_edge();
         rd(8'h00, 32'he0, 32'hff, RESP_OKAY);
         for (int i = 0; i < 3; i++)
            rd(8'(8'h3c + 4 * i), {24'h0, tv[23 - 8 * i -: 8]}, 32'hff, RESP_OKAY);
         for (int i = 0; i < 4; i++)
            rd(8'(8'h54 + 4 * i), {24'h0, dv[31 - 8 * i -: 8]}, 32'hff, RESP_OKAY);
         wr(8'h00, 32'h40, 4'hf, RESP_OKAY);
         rd(8'h00, 32'ha0, 32'hff, RESP_OKAY);
         wr(8'h00, 32'h80, 4'hf, RESP_OKAY);
         wr(8'h00, 32'h20, 4'hf, RESP_OKAY);
         rd(8'h00, 32'h00, 32'hff, RESP_OKAY);
      end
      // a delivery that is not decimal leaves flags and bytes alone
      time_in <= {8'h1a, 8'h00, 8'h00};
      time_new <= 1'b1;
      pulse_edge();
      wr(8'h3c, 32'hff, 4'hf, RESP_OKAY);
      rd(8'h00, 32'h00, 32'hff, RESP_OKAY);
      rd(8'h3c, {24'h0, tv.hours}, 32'hff, RESP_OKAY);
      // mailbox handshake bits, one at a time
      r = 32'h0;
      for (int b = 1; b < 7; b++)
      begin
         r[b] = 1'b1;
         wr(8'h0c, 32'h1 << b, 4'hf, RESP_OKAY);
         rd(8'h0c, r, 32'hff, RESP_OKAY);
      end
      wr(8'h0c, 32'h81, 4'hf, RESP_OKAY);
      rd(8'h0c, 32'h7e, 32'hff, RESP_OKAY);
      mbox_read <= 1'b1;
      pulse_edge();
      rd(8'h0c, 32'hfe, 32'hff, RESP_OKAY);
      mbox_cmd <= '{set: 8'h01, clr: 8'h00};
      pulse_edge();
      @(negedge aclk);
      check("mailbox_flags", {24'h0, mailbox_flags}, 32'hff);
      wr(8'h0c, 32'hff00, 4'hf, RESP_OKAY);
      rd(8'h0c, 32'h00, 32'hff, RESP_OKAY);
      // control job: number written last, cleared by the panel when done
      wr(8'h10, 32'h29, 4'hf, RESP_OKAY);
      rd(8'h10, 32'h29, 32'hffff, RESP_OKAY);
      @(negedge aclk);
      check("job_number", {16'h0, job_number}, 32'd41);
      check("job_pending", {31'h0, job_pending}, 32'h1);
      job_done <= 1'b1;
      pulse_edge();
      rd(8'h10, 32'h0, 32'hffff, RESP_OKAY);
      @(negedge aclk);
      check("job_pending", {31'h0, job_pending}, 32'h0);
      wr(8'h10, 32'hffff, 4'h1, RESP_OKAY);
      rd(8'h10, 32'h00ff, 32'hffff, RESP_OKAY);
      // unmapped and unaligned places
      rd(8'h08, 32'h0, 32'hffffffff, RESP_SLVERR);
      rd(8'h01, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(8'h08, 32'h1, 4'hf, RESP_SLVERR);
      repeat (2) @(negedge aclk);
      check("notes left", 32'(rq.size() + bq.size()), 32'h0);
      report_and_stop();
   end
endmodule // tb_panel_handshake_flags
